/* pkg/cir_defines.svh */
// Constants for the card information register bank
`ifndef CIR_DEFINES_SVH
`define CIR_DEFINES_SVH
`define CIR_ADDR_DEFAULT 16'h0001
`define CIR_ADDR_BROADCAST 16'h0000
`define CIR_STRUCT_VAL 2'h1
`define CIR_STDVER_VAL 4'h2
`define CIR_ACC_ABS_VAL 8'h0E
`define CIR_ACC_CLK_VAL 8'h01
`define CIR_SPEED_VAL 8'h2A
`define CIR_CLASS_MAP_VAL 12'h0FF
`define CIR_BLKLEN_VAL 4'h9
`define CIR_CRC_POLY 7'h09
`define CIR_SEL_COND 2'h0
`define CIR_SEL_IDENT 2'h1
`define CIR_SEL_PARAM 2'h2
`define CIR_PARAM_USER_W 74
`define CIR_COND_LAST 7'd31
`define CIR_REC_LAST 7'd127
`endif

/* pkg/cir_pkg.sv */
// Types for the card information register bank
package cir_pkg;
  // Which information register a read command asks for
  typedef enum logic [1:0] {
    CIR_RD_COND = 2'h0,
    CIR_RD_IDENT = 2'h1,
    CIR_RD_PARAM = 2'h2,
    CIR_RD_NONE = 2'h3
  } cir_sel_t;
  // Read request from the command decoder
  typedef struct packed {
    logic start;
    cir_sel_t sel;
  } cir_rd_req_t;
  // Serial answer stream
  typedef struct packed {
    logic valid;
    logic bit_out;
    logic last;
  } cir_stream_t;
  // Factory identity fields
  typedef struct packed {
    logic [7:0] maker;
    logic [15:0] oem_application_code;
    logic [47:0] product_name;
    logic [7:0] product_revision;
    logic [31:0] product_serial;
    logic [7:0] manufacture_date;
  } cir_ident_t;
  // Serialiser states
  typedef enum {CIR_IDLE, CIR_SHIFT} cir_state_t;
endpackage

/* rtl/cir_bank.sv */
// Card information register bank: conditions, identity, address and parameter records
//
// Overview of operation
// - Identity record holds maker, OEM, name, serial, CRC fields
// - Identity CRC7 over bits 127..8, poly x7+x3+1
// - Host assigns address by set command; never readable
// - Power-up reset loads address 0x0001
// - Address zero reserved; deselect zero sends standby
// - Read-only 32-bit operating conditions register
// - Records read only by their dedicated commands
// - SPI mode: conditions, identity, parameters; no address
// - Parameter record structure 1, version 2, reserved zero
// - Access time fields 0x0E and 0x01
// - Transfer rate code 0x2A at bits 103..96
// - Command class map 0x0FF at bits 95..84
// - Read block length code 0x9 at 83..80
// - Partial read set, misalign and driver flags clear
`timescale 1ns/1ps
`include "cir_defines.svh"
module cir_bank
  import cir_pkg::*;
#(
  parameter logic [31:0] COND_VALUE = 32'h80FF8000,  // Voltage window and ready bit
  parameter cir_ident_t IDENT = '{8'h5A, 16'h1234, 48'h414243444546, 8'h10, 32'h00000001, 8'h01}, // Arbitrary values
  parameter logic [`CIR_PARAM_USER_W-1:0] PARAM_LOW_DEFAULT = '0   // Fields below bit 74
) (
  input wire logic mclk,
  input wire logic reset_n,                  // Power-up detector reset
  input wire logic spi_mode,                 // Card runs in SPI mode
  input wire cir_rd_req_t rd_req,            // Dedicated read command
  input wire logic set_addr_cmd,             // Set-relative-address command pulse
  input wire logic [15:0] set_addr_value,    // Address carried by it
  input wire logic select_cmd,               // Select/deselect command pulse
  input wire logic [15:0] select_addr,       // Address carried by it
  input wire logic param_prog_we,            // Program user part of parameter record
  input wire logic [`CIR_PARAM_USER_W-1:0] param_prog_data, // New user part
  input wire logic shift_en,                 // One bit per link clock
  output cir_stream_t rd_stream,             // Serial record answer
  output logic addr_match,                   // Addressed command targets this card
  output logic go_standby,                   // Deselect-all seen
  output logic [6:0] ident_crc               // Computed identity checksum
);

  // CRC7 over a vector, MSB first
  function automatic logic [6:0] crc7(input logic [119:0] msg);
    logic [6:0] c;
    logic fb;
    c = '0;
    for (int i = 119; i >= 0; i--) begin
      fb = msg[i] ^ c[6];
      c = {c[5:0], 1'b0};
      if (fb) begin
        c = c ^ `CIR_CRC_POLY;
      end
    end
    return c;
  endfunction

  // The address has no read path at all: only the match pulse reveals it
  logic [15:0] addr_q, addr_d;               // Relative address, write only
  logic [`CIR_PARAM_USER_W-1:0] param_low_q, param_low_d;  // Programmable parameter bits
  logic [127:0] shreg_q, shreg_d;            // Output shifter
  logic [6:0] cnt_q, cnt_d;                  // Bits remaining minus one
  cir_state_t state_q, state_d;              // Serialiser state
  logic standby_q, standby_d;                // Standby pulse register
  logic match_q, match_d;                    // Address match register
  logic [127:0] ident_word;                  // Assembled identity record
  logic [127:0] param_word;                  // Assembled parameter record

  // Identity record with checksum and fixed one
  // The checksum is a constant of the parameters, so it costs no registers
  assign ident_crc = crc7(IDENT);
  assign ident_word = {IDENT, ident_crc, 1'b1};

  // Parameter record layout, fixed fields above the user part
  assign param_word = {`CIR_STRUCT_VAL, `CIR_STDVER_VAL, 2'b00,
                       `CIR_ACC_ABS_VAL, `CIR_ACC_CLK_VAL,
                       `CIR_SPEED_VAL,
                       `CIR_CLASS_MAP_VAL,
                       `CIR_BLKLEN_VAL,
                       1'b1, 1'b0, 1'b0, 1'b0,
                       2'b00, param_low_q};

  // Address register and command decode next state
  always_comb begin
    addr_d = addr_q;
    param_low_d = param_low_q;
    standby_d = 1'b0;
    match_d = 1'b0;
    // Zero cannot be assigned; SPI mode has no address register
    if (set_addr_cmd && !spi_mode && set_addr_value != `CIR_ADDR_BROADCAST) begin
      addr_d = set_addr_value;
    end
    if (select_cmd && !spi_mode) begin
      if (select_addr == `CIR_ADDR_BROADCAST) begin
        standby_d = 1'b1;
      end else if (select_addr == addr_q) begin
        match_d = 1'b1;
      end
    end
    // User part takes effect at the next record load
    if (param_prog_we) begin
      param_low_d = param_prog_data;
    end
  end

  // Address, parameter and pulse registers; power-up reset restores defaults
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      addr_q <= `CIR_ADDR_DEFAULT;
      param_low_q <= PARAM_LOW_DEFAULT;
      standby_q <= 1'b0;
      match_q <= 1'b0;
    end else begin
      addr_q <= addr_d;
      param_low_q <= param_low_d;
      standby_q <= standby_d;
      match_q <= match_d;
    end
  end

  assign go_standby = standby_q;
  assign addr_match = match_q;

  // Serialiser next state: load on a read command, shift MSB first
  always_comb begin
    state_d = state_q;
    shreg_d = shreg_q;
    cnt_d = cnt_q;
    case (state_q)
      CIR_IDLE: begin
        if (rd_req.start) begin
          case (rd_req.sel)
            CIR_RD_COND: begin
              // Short register sits left-aligned so the MSB leads
              shreg_d = {COND_VALUE, 96'h0};
              cnt_d = `CIR_COND_LAST;
              state_d = CIR_SHIFT;
            end
            CIR_RD_IDENT: begin
              shreg_d = ident_word;
              cnt_d = `CIR_REC_LAST;
              state_d = CIR_SHIFT;
            end
            CIR_RD_PARAM: begin
              shreg_d = param_word;
              cnt_d = `CIR_REC_LAST;
              state_d = CIR_SHIFT;
            end
            default: begin
              state_d = CIR_IDLE;
            end
          endcase
        end
      end
      CIR_SHIFT: begin
        if (shift_en) begin
          shreg_d = {shreg_q[126:0], 1'b0};
          if (cnt_q == 7'd0) begin
            state_d = CIR_IDLE;
          end else begin
            cnt_d = cnt_q - 7'd1;
          end
        end
      end
      default: begin
        state_d = CIR_IDLE;
      end
    endcase
  end

  // Serialiser registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= CIR_IDLE;
      shreg_q <= '0;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      shreg_q <= shreg_d;
      cnt_q <= cnt_d;
    end
  end

  // Current bit is the shifter MSB
  assign rd_stream.valid = (state_q == CIR_SHIFT);
  assign rd_stream.bit_out = shreg_q[127];
  assign rd_stream.last = (state_q == CIR_SHIFT) && (cnt_q == 7'd0);

endmodule

/* tb/cir_bank_monitor.sv */
// Assertion checker for the register bank ports
`timescale 1ns/1ps
module cir_bank_monitor
  import cir_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic spi_mode,
  input wire cir_rd_req_t rd_req,
  input wire logic select_cmd,
  input wire logic [15:0] select_addr,
  input wire logic shift_en,
  input wire cir_stream_t rd_stream,
  input wire logic addr_match,
  input wire logic go_standby
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  property p_std; select_cmd && !spi_mode && select_addr == 16'h0000 |=> go_standby; endproperty
  a_std: assert property (p_std) else $error("standby missing");
  property p_spi; select_cmd && spi_mode |=> !go_standby && !addr_match; endproperty
  a_spi: assert property (p_spi) else $error("select in spi");
  property p_src; go_standby |-> $past(select_cmd) && $past(select_addr) == 16'h0000; endproperty
  a_src: assert property (p_src) else $error("stray standby");
  property p_match; addr_match |-> $past(select_cmd) && !$past(spi_mode) && $past(select_addr) != 16'h0000; endproperty
  a_match: assert property (p_match) else $error("stray match");
  property p_go; rd_req.start && rd_req.sel != CIR_RD_NONE && !rd_stream.valid |=> rd_stream.valid; endproperty
  a_go: assert property (p_go) else $error("read not started");
  property p_none; rd_req.start && rd_req.sel == CIR_RD_NONE && !rd_stream.valid |=> !rd_stream.valid; endproperty
  a_none: assert property (p_none) else $error("bad read started");
  property p_hold; rd_stream.valid && !shift_en |=> rd_stream.valid && $stable(rd_stream.bit_out); endproperty
  a_hold: assert property (p_hold) else $error("bit not held");
  property p_end; rd_stream.valid && rd_stream.last && shift_en |=> !rd_stream.valid; endproperty
  a_end: assert property (p_end) else $error("stream overran");
endmodule

/* tb/cir_bank_tb.sv */
// Self-checking testbench for the register bank
`timescale 1ns/1ps
module cir_bank_tb;
  import cir_pkg::*;
  localparam logic [31:0] COND = 32'h80FF8000;
  localparam cir_ident_t ID = '{8'hA5, 16'h0F0F, 48'h313233343536, 8'h22, 32'h89ABCDEF, 8'h3C}; // Arbitrary
  localparam logic [73:0] PAT = 74'h2AAAAAAAAAAAAAAAAA5;
  logic mclk = 1'b0, reset_n = 1'b0, spi_mode = 1'b0, set_addr_cmd = 1'b0, select_cmd = 1'b0;
  logic param_prog_we = 1'b0, stall = 1'b0, shift_en, addr_match, go_standby;
  logic [15:0] set_addr_value = 16'h0000, select_addr = 16'h0000;
  logic [73:0] param_prog_data = 74'h0;
  logic [6:0] ident_crc;
  logic [127:0] rec;
  logic [1:0] pr;
  cir_rd_req_t rd_req = '0;
  cir_stream_t rd_stream;
  int miscompares = 0, comparisons = 0, cycles = 0, n;
  cir_bank #(.COND_VALUE(COND), .IDENT(ID), .PARAM_LOW_DEFAULT(74'h0)) i_cir_bank (.mclk(mclk), .reset_n(reset_n),
    .spi_mode(spi_mode), .rd_req(rd_req), .set_addr_cmd(set_addr_cmd), .set_addr_value(set_addr_value),
    .select_cmd(select_cmd), .select_addr(select_addr), .param_prog_we(param_prog_we),
    .param_prog_data(param_prog_data), .shift_en(shift_en), .rd_stream(rd_stream), .addr_match(addr_match),
    .go_standby(go_standby), .ident_crc(ident_crc));
  cir_host_model i_cir_host_model (.mclk(mclk), .stall(stall), .shift_en(shift_en));
  initial forever #12.5 mclk = ~mclk;
  // Cut a hang short
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      final_report();
    end
  end
  function automatic logic [6:0] crc7(logic [119:0] m);
    logic [6:0] c = 7'h00;
    for (int i = 119; i >= 0; i--) c = {c[5:0], 1'b0} ^ ((c[6] ^ m[i]) ? 7'h09 : 7'h00);
    return c;
  endfunction
  task automatic check(string what, logic [127:0] exp, logic [127:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rst;
    reset_n <= 1'b0;
    repeat (8) @(negedge mclk);
    reset_n <= 1'b1;
  endtask
  // Set address (sel 0) or select (sel 1); pr holds {match, standby}
  task automatic cmd(logic sel, logic [15:0] a);
    @(negedge mclk);
    set_addr_cmd <= !sel;
    select_cmd <= sel;
    set_addr_value <= a;
    select_addr <= a;
    @(negedge mclk);
    pr = {addr_match, go_standby};
    set_addr_cmd <= 1'b0;
    select_cmd <= 1'b0;
  endtask
  // Request a record and collect the bits the host takes
  task automatic rd(cir_sel_t s);
    repeat (2) @(negedge mclk);
    rd_req <= '{1'b1, s};
    rec = '0;
    n = 0;
    repeat (300) begin
      @(negedge mclk);
      rd_req <= '0;
      #1;
      if (rd_stream.valid && shift_en) begin
        rec = {rec[126:0], rd_stream.bit_out};
        n++;
        if (rd_stream.last) break;
      end
    end
  endtask
  task automatic final_report;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    rst();
    cmd(1, 16'h0001);
    check("default match", 2'h2, pr);
    cmd(0, 16'h1234);
    cmd(0, 16'h0000);
    cmd(1, 16'h1234);
    check("set match", 2'h2, pr);
    cmd(1, 16'h0001);
    check("old address", 2'h0, pr);
    cmd(1, 16'h0000);
    check("standby", 2'h1, pr);
    spi_mode <= 1'b1;
    cmd(0, 16'h5555);
    cmd(1, 16'h5555);
    check("spi select", 2'h0, pr);
    rd(CIR_RD_COND);
    check("conditions", {96'h0, COND}, rec);
    check("conditions length", 32, n);
    spi_mode <= 1'b0;
    cmd(1, 16'h1234);
    check("spi set refused", 2'h2, pr);
    rd(CIR_RD_IDENT);
    check("identity", {ID, crc7(ID), 1'h1}, rec);
    check("identity crc", crc7(ID), ident_crc);
    @(negedge mclk);
    param_prog_data <= PAT;
    param_prog_we <= 1'b1;
    @(negedge mclk);
    param_prog_we <= 1'b0;
    stall <= 1'b1;
    rd(CIR_RD_PARAM);
    check("parameters", {2'h1, 4'h2, 2'h0, 8'h0E, 8'h01, 8'h2A, 12'h0FF, 4'h9, 4'h8, 2'h0, PAT}, rec);
    check("parameters length", 128, n);
    rd(CIR_RD_NONE);
    check("no record", 0, n);
    rst();
    cmd(1, 16'h0001);
    check("match after reset", 2'h2, pr);
    final_report();
  end
endmodule
bind cir_bank cir_bank_monitor i_cir_bank_monitor (.mclk(mclk), .reset_n(reset_n), .spi_mode(spi_mode),
  .rd_req(rd_req), .select_cmd(select_cmd), .select_addr(select_addr), .shift_en(shift_en),
  .rd_stream(rd_stream), .addr_match(addr_match), .go_standby(go_standby));

/* tb/cir_host_model.sv */
// Host model that paces the serial record answer
`timescale 1ns/1ps
module cir_host_model (
  input wire logic mclk,
  input wire logic stall,
  output logic shift_en
);
  // One bit per cycle, or every other cycle while stalling
  always @(negedge mclk) shift_en <= !(stall && shift_en);
endmodule
